// ==== src/mpdi_defines.vh ====
// Constants of the MII data interface: timing, codes and reset values
`ifndef MPDI_DEFINES_VH
`define MPDI_DEFINES_VH

// System clock and derived MII nibble clock
`define MPDI_SYS_CLK_KHZ 40000
`define MPDI_MII_CLK_KHZ 5000
`define MPDI_CLK_DIV (`MPDI_SYS_CLK_KHZ / `MPDI_MII_CLK_KHZ)

// Phases of the eight-cycle nibble period
`define MPDI_PH_W 3
`define MPDI_PH_LAST 3'h7
`define MPDI_PH_SAMPLE 3'h6
`define MPDI_PH_LOAD 3'h7
`define MPDI_PH_BIT_LAST 3'h4

// Code groups, bit 4 first on the line
`define MPDI_CG_IDLE 5'h1F
`define MPDI_CG_J 5'h18
`define MPDI_CG_K 5'h11
`define MPDI_CG_T 5'h0D
`define MPDI_CG_R 5'h07
`define MPDI_CG_H 5'h04
`define MPDI_CG_JK 10'h311
`define MPDI_PREAMBLE_NIB 4'h5

// Scrambler
`define MPDI_LFSR_W 11
`define MPDI_LFSR_SEED 11'h7FF
`define MPDI_LOCK_BITS 5'h18

// Reset values and last bit count of a code group
`define MPDI_RST_NIB 4'h0
`define MPDI_RST_BIT 1'b0
`define MPDI_RST_PH 3'h0
`define MPDI_RST_CNT 3'h0
`define MPDI_RST_WIN 10'h000
`define MPDI_RST_LOCK 5'h00
`define MPDI_GRP_LAST 3'h4

`endif

// ==== src/mpdi_lfsr.v ====
// Eleven-bit additive scrambler key generator, x^11 + x^9 + 1
`timescale 1ns/1ps
module mpdi_lfsr (
    // Clock and reset
    input wire clk_in,
    input wire rst_in,
    // Control
    input wire step_in,
    input wire load_in,
    input wire load_bit_in,
    // Key
    output wire key_out
);
`include "mpdi_defines.vh"

    reg [`MPDI_LFSR_W-1:0] state_q;

    // Key is the feedback of the current state
    assign key_out = state_q[10] ^ state_q[8];

    // Free run, or track keys deduced from the line
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= `MPDI_LFSR_SEED;
        end else if (step_in) begin
            if (load_in) begin
                state_q <= {state_q[9:0], load_bit_in};
            end else begin
                state_q <= {state_q[9:0], key_out};
            end
        end
    end
endmodule

// ==== src/mpdi_core.v ====
// MII data path of a 20 Mbit/s PHY: 4B5B, scrambling, serial line
`timescale 1ns/1ps
`include "mpdi_defines.vh"

// Functional notes
// RULE1: MAC drives the transmit nibble in step with our transmit clock.
// RULE2: Each transmit clock period with transmit enable high, nibble is taken.
// RULE3: A free-running transmit clock is driven out to the MAC.
// RULE4: MAC raises transmit enable exactly while sending frame nibbles.
// RULE5: Transmit error with enable sends an error symbol in the frame. Code sends J and K regardless of it.
// RULE6: Receive nibble is presented each receive period with data valid high.
// RULE7: A free-running receive clock is driven out to the MAC.
// RULE8: Data valid rises by the start delimiter, falls before the end delimiter.
// RULE9: Receive error is clock-aligned, held one period per detected error.
// RULE10: Carrier sense is high while transmit or receive is active.
// RULE11: Nibbles run at the MII clock; symbols run five times faster.
// RULE12: Transmit nibbles become scrambled code groups on one serial stream.
// RULE13: Frame starts with J then K, then each nibble's five-bit code.
// RULE14: After enable drops, T then R, then idle codes until next frame.
// RULE15: Reset holds valid, error and carrier sense low; enable ignored.
module mpdi_core (
    // Clock, reset and enable
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // MII transmit side
    output wire tx_clk_out,
    input wire tx_en_in,
    input wire [3:0] txd_in,
    input wire tx_er_in,
    // MII receive side
    output wire rx_clk_out,
    output wire rx_dv_out,
    output wire [3:0] rxd_out,
    output wire rx_er_out,
    output wire crs_out,
    // Serial line
    output wire line_tx_out,
    input wire line_rx_in
);

    // Transmit encoder states
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_K = 4'h2;
    localparam [3:0] ST_DATA = 4'h4;
    localparam [3:0] ST_R = 4'h8;
    localparam SYNC_W = 7;

    // Nibble to code group
    function [4:0] enc;
        input [3:0] nib;
        begin
            case (nib)
                4'h0: enc = 5'h1E;
                4'h1: enc = 5'h09;
                4'h2: enc = 5'h14;
                4'h3: enc = 5'h15;
                4'h4: enc = 5'h0A;
                4'h5: enc = 5'h0B;
                4'h6: enc = 5'h0E;
                4'h7: enc = 5'h0F;
                4'h8: enc = 5'h12;
                4'h9: enc = 5'h13;
                4'hA: enc = 5'h16;
                4'hB: enc = 5'h17;
                4'hC: enc = 5'h1A;
                4'hD: enc = 5'h1B;
                4'hE: enc = 5'h1C;
                default: enc = 5'h1D;
            endcase
        end
    endfunction

    // Code group to {valid, nibble}
    function [4:0] dec;
        input [4:0] cg;
        begin
            case (cg)
                5'h1E: dec = 5'h10;
                5'h09: dec = 5'h11;
                5'h14: dec = 5'h12;
                5'h15: dec = 5'h13;
                5'h0A: dec = 5'h14;
                5'h0B: dec = 5'h15;
                5'h0E: dec = 5'h16;
                5'h0F: dec = 5'h17;
                5'h12: dec = 5'h18;
                5'h13: dec = 5'h19;
                5'h16: dec = 5'h1A;
                5'h17: dec = 5'h1B;
                5'h1A: dec = 5'h1C;
                5'h1B: dec = 5'h1D;
                5'h1C: dec = 5'h1E;
                5'h1D: dec = 5'h1F;
                default: dec = 5'h00;
            endcase
        end
    endfunction

    reg [2:0] phase_q;
    reg mii_clk_q;
    wire [2:0] phase_d;
    wire bit_stb;
    wire [SYNC_W-1:0] raw_in;
    wire [SYNC_W-1:0] sync_out;
    wire s_en;
    wire s_er;
    wire [3:0] s_txd;
    wire s_line;
    reg [3:0] tx_st_q;
    reg [4:0] sym_q;
    reg [4:0] sh_q;
    reg line_tx_q;
    wire tx_key;
    wire rx_key;
    wire rx_d;
    wire [9:0] win_d;
    wire [4:0] grp;
    wire [4:0] dec_grp;
    reg [9:0] win_q;
    reg rx_frame_q;
    reg [2:0] cnt_q;
    reg pend_q;
    reg [3:0] pend_nib_q;
    reg pend_err_q;
    reg rx_dv_q;
    reg [3:0] rxd_q;
    reg rx_er_q;
    reg crs_q;
    reg [4:0] lock_cnt_q;
    wire rx_locked;

    // Nibble period phase and MII clock; high in phases 0 to 3
    assign phase_d = (phase_q == `MPDI_PH_LAST) ? `MPDI_RST_PH :
                     phase_q + 3'h1;
    assign bit_stb = ce_in && (phase_q <= `MPDI_PH_BIT_LAST); // see RULE11
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_q <= `MPDI_RST_PH;
            mii_clk_q <= `MPDI_RST_BIT;
        end else if (ce_in) begin
            phase_q <= phase_d;
            mii_clk_q <= ~phase_d[2]; // see RULE3 see RULE7
        end
    end
    assign tx_clk_out = mii_clk_q;
    assign rx_clk_out = mii_clk_q;

    // Two-stage synchronisers for the MII transmit and serial line inputs
    assign raw_in = {line_rx_in, tx_er_in, tx_en_in, txd_in};
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
            reg meta_q;
            reg stab_q;
            always @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_q <= `MPDI_RST_BIT;
                    stab_q <= `MPDI_RST_BIT;
                end else if (ce_in) begin
                    meta_q <= raw_in[gi];
                    stab_q <= meta_q;
                end
            end
            assign sync_out[gi] = stab_q;
        end
    endgenerate
    assign s_txd = sync_out[3:0];
    assign s_en = sync_out[4];
    assign s_er = sync_out[5];
    assign s_line = sync_out[6];

    // Encoder: MAC inputs sampled mid low phase of the transmit clock
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_st_q <= ST_IDLE; // see RULE15
            sym_q <= `MPDI_CG_IDLE;
        end else if (ce_in && phase_q == `MPDI_PH_SAMPLE) begin
            case (tx_st_q)
                ST_IDLE: begin
                    if (s_en) begin // see RULE1 see RULE4
                        sym_q <= `MPDI_CG_J; // see RULE13
                        tx_st_q <= ST_K;
                    end else begin
                        sym_q <= `MPDI_CG_IDLE; // see RULE14
                    end
                end
                ST_K: begin
                    if (s_en) begin
                        sym_q <= `MPDI_CG_K; // see RULE13
                        tx_st_q <= ST_DATA;
                    end else begin
                        sym_q <= `MPDI_CG_T;
                        tx_st_q <= ST_R;
                    end
                end
                ST_DATA: begin
                    if (s_en && s_er) begin
                        sym_q <= `MPDI_CG_H; // see RULE5
                    end else if (s_en) begin
                        sym_q <= enc(s_txd); // see RULE2 see RULE13
                    end else begin
                        sym_q <= `MPDI_CG_T; // see RULE14
                        tx_st_q <= ST_R;
                    end
                end
                ST_R: begin
                    sym_q <= `MPDI_CG_R; // see RULE14
                    tx_st_q <= ST_IDLE;
                end
                default: begin
                    sym_q <= `MPDI_CG_IDLE;
                    tx_st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Transmit scrambler key
    mpdi_lfsr u_tx_lfsr (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .step_in(bit_stb),
        .load_in(1'b0),
        .load_bit_in(1'b0),
        .key_out(tx_key)
    );

    // Serialiser: five scrambled bits per nibble period
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sh_q <= `MPDI_CG_IDLE;
            line_tx_q <= `MPDI_RST_BIT;
        end else if (ce_in && phase_q == `MPDI_PH_LOAD) begin
            sh_q <= sym_q;
        end else if (bit_stb) begin
            line_tx_q <= sh_q[4] ^ tx_key; // see RULE12
            sh_q <= {sh_q[3:0], 1'b0};
        end
    end
    assign line_tx_out = line_tx_q;

    // Lock once on idle after reset; loading keys later would take the
    // zeros of J/K or R as keys and corrupt the key history
    assign rx_locked = (lock_cnt_q == `MPDI_LOCK_BITS);
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lock_cnt_q <= `MPDI_RST_LOCK;
        end else if (bit_stb && !rx_locked) begin
            lock_cnt_q <= lock_cnt_q + 5'h01;
        end
    end

    // Receive descrambler: tracks idle keys until locked, then free runs
    mpdi_lfsr u_rx_lfsr (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .step_in(bit_stb),
        .load_in(~rx_locked),
        .load_bit_in(~s_line),
        .key_out(rx_key)
    );
    assign rx_d = s_line ^ rx_key;
    assign win_d = {win_q[8:0], rx_d};
    assign grp = win_d[4:0];
    assign dec_grp = dec(grp);

    // Alignment on J/K, then one code group per five bits
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            win_q <= `MPDI_RST_WIN;
            rx_frame_q <= `MPDI_RST_BIT;
            cnt_q <= `MPDI_RST_CNT;
            pend_q <= `MPDI_RST_BIT;
            pend_nib_q <= `MPDI_RST_NIB;
            pend_err_q <= `MPDI_RST_BIT;
        end else if (ce_in) begin
            if (phase_q == `MPDI_PH_SAMPLE) begin
                pend_q <= `MPDI_RST_BIT;
                pend_err_q <= `MPDI_RST_BIT;
            end
            if (bit_stb) begin
                win_q <= win_d;
                if (!rx_frame_q) begin
                    if (rx_locked && win_d == `MPDI_CG_JK) begin
                        rx_frame_q <= 1'b1;
                        cnt_q <= `MPDI_RST_CNT;
                        pend_q <= 1'b1; // see RULE8
                        pend_nib_q <= `MPDI_PREAMBLE_NIB;
                    end
                end else if (cnt_q == `MPDI_GRP_LAST) begin
                    cnt_q <= `MPDI_RST_CNT;
                    if (grp == `MPDI_CG_T) begin
                        rx_frame_q <= 1'b0; // see RULE8
                    end else if (grp == `MPDI_CG_IDLE) begin
                        rx_frame_q <= 1'b0;
                        pend_err_q <= 1'b1; // see RULE9
                    end else begin
                        pend_q <= 1'b1;
                        pend_nib_q <= dec_grp[3:0];
                        pend_err_q <= ~dec_grp[4]; // see RULE9
                    end
                end else begin
                    cnt_q <= cnt_q + 3'h1;
                end
            end
        end
    end

    // MII receive outputs, updated while the receive clock is low
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_dv_q <= `MPDI_RST_BIT; // see RULE15
            rxd_q <= `MPDI_RST_NIB;
            rx_er_q <= `MPDI_RST_BIT;
            crs_q <= `MPDI_RST_BIT;
        end else if (ce_in && phase_q == `MPDI_PH_SAMPLE) begin
            rx_dv_q <= pend_q; // see RULE6
            rxd_q <= pend_q ? pend_nib_q : `MPDI_RST_NIB;
            rx_er_q <= pend_err_q; // see RULE9
            crs_q <= rx_frame_q || s_en ||
                     (tx_st_q != ST_IDLE); // see RULE10
        end
    end
    assign rx_dv_out = rx_dv_q;
    assign rxd_out = rxd_q;
    assign rx_er_out = rx_er_q;
    assign crs_out = crs_q;
endmodule

// ==== dv/mpdi_core_sva.sv ====
// Port assertions for the MII data path
`timescale 1ns/1ps
module mpdi_core_sva (
    // Clock, reset and enable
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    // MII transmit side
    input wire tx_clk_out,
    input wire tx_en_in,
    input wire [3:0] txd_in,
    input wire tx_er_in,
    // MII receive side
    input wire rx_clk_out,
    input wire rx_dv_out,
    input wire [3:0] rxd_out,
    input wire rx_er_out,
    input wire crs_out,
    // Serial line
    input wire line_tx_out,
    input wire line_rx_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Reset, clocks and receive timing
    chk_rst_quiet: assert property (disable iff (1'b0) rst_in |->
        !rx_dv_out && !rx_er_out && !crs_out && !line_tx_out)
        else $error("outputs active in reset");
    // First high phase after reset is one cycle short
    chk_txclk_wave: assert property ($rose(tx_clk_out) &&
        !$past(rst_in, 2) |->
        tx_clk_out[*4] ##1 !tx_clk_out[*4] ##1 tx_clk_out)
        else $error("transmit clock not 4 high 4 low");
    chk_rxclk_same: assert property (rx_clk_out == tx_clk_out)
        else $error("receive clock differs");
    chk_dv_hold: assert property ($changed(rx_dv_out) |->
        !tx_clk_out && !$past(tx_clk_out) ##1 $stable(rx_dv_out)[*7])
        else $error("valid moved off its phase");
    chk_rxd_hold: assert property ($changed(rxd_out) |=>
        $stable(rxd_out)[*7])
        else $error("receive nibble not held");
    chk_rxd_idle: assert property (!rx_dv_out |-> rxd_out == 4'h0)
        else $error("nibble without valid");
    chk_er_hold: assert property ($rose(rx_er_out) |=> rx_er_out[*7])
        else $error("receive error shorter than a period");
    // Carrier follows both directions
    chk_crs_tx: assert property (tx_en_in[*8] |-> ##[0:10] crs_out)
        else $error("no carrier while sending");
    chk_crs_rx: assert property (rx_dv_out |-> crs_out)
        else $error("no carrier while receiving");
    chk_crs_idle: assert property ($fell(crs_out) |->
        !rx_dv_out && !tx_en_in && !$past(tx_en_in, 4))
        else $error("carrier dropped while busy");
    cover property ($rose(rx_dv_out));
    cover property ($rose(rx_er_out));
    cover property ($fell(crs_out));
endmodule

bind mpdi_core mpdi_core_sva i_sva (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .tx_clk_out(tx_clk_out), .tx_en_in(tx_en_in),
    .txd_in(txd_in), .tx_er_in(tx_er_in), .rx_clk_out(rx_clk_out),
    .rx_dv_out(rx_dv_out), .rxd_out(rxd_out), .rx_er_out(rx_er_out),
    .crs_out(crs_out), .line_tx_out(line_tx_out), .line_rx_in(line_rx_in));

// ==== dv/mpdi_mac_model.sv ====
// MAC-side transmit driver for the MII data path
`timescale 1ns/1ps
module mpdi_mac_model (
    // Clock from the PHY
    input wire tx_clk_in,
    // MII transmit side
    output logic tx_en_out,
    output logic [3:0] txd_out,
    output logic tx_er_out
);
    // Enable high from time zero; the PHY must ignore it in reset
    initial begin
        tx_en_out = 1'b1;
        txd_out = 4'hA;
        tx_er_out = 1'b0;
    end
    // One nibble a period, launched just after the rising edge
    task automatic put(input logic en, input logic [3:0] d, input logic er);
        @(posedge tx_clk_in);
        #1;
        tx_en_out = en;
        txd_out = en ? d : ~txd_out;
        tx_er_out = en & er;
    endtask
endmodule

// ==== dv/mii_phy_data_interface_tb.sv ====
// Bench: MAC model, line loopback and receive scoreboard
`timescale 1ns/1ps
module mii_phy_data_interface_tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [5:0] loop_q = 6'h00;
    logic [15:0] rng = 16'h0008;
    logic [4:0] exp_q[$];
    logic [4:0] exp_v;
    int num_errors = 0;
    int check_count = 0;
    wire tx_clk, tx_en, tx_er, rx_clk, rx_dv, rx_er, crs, line_tx;
    wire [3:0] txd, rxd;
    wire line_rx = loop_q[5];
    // PHY and MAC partner
    mpdi_core i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .tx_clk_out(tx_clk), .tx_en_in(tx_en), .txd_in(txd),
        .tx_er_in(tx_er), .rx_clk_out(rx_clk), .rx_dv_out(rx_dv),
        .rxd_out(rxd), .rx_er_out(rx_er), .crs_out(crs),
        .line_tx_out(line_tx), .line_rx_in(line_rx));
    mpdi_mac_model i_mac (.tx_clk_in(tx_clk), .tx_en_out(tx_en),
        .txd_out(txd), .tx_er_out(tx_er));
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // Six-cycle loopback puts each group on the sampling phases
    always @(posedge clk_in) begin
        loop_q <= {loop_q[4:0], line_tx};
    end
    function automatic logic [15:0] xs(input logic [15:0] x);
        x = x ^ (x << 7);
        x = x ^ (x >> 9);
        return x ^ (x << 8);
    endfunction
    task automatic cmp_nib(input logic [4:0] got, input logic [4:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t nibble %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Scoreboard: oldest note against each valid receive period
    always @(posedge rx_clk) begin
        if (rx_dv !== 1'b0) begin
            if (exp_q.size() == 0) begin
                cmp_bit(1'b1, 1'b0);
            end else begin
                exp_v = exp_q.pop_front();
                if (exp_v[4]) begin
                    cmp_bit(rx_er, 1'b1);
                end else begin
                    cmp_nib({rx_er, rxd}, exp_v);
                end
            end
        end
    end
    // Frame: two preamble nibbles, data, one nibble may carry an error
    task automatic frame(input int len, input int er_at);
        logic [3:0] d;
        exp_q.push_back(5'h05);
        i_mac.put(1'b1, 4'h5, 1'b0);
        i_mac.put(1'b1, 4'h5, 1'b0);
        for (int i = 0; i < len; i++) begin
            rng = xs(rng);
            d = rng[3:0];
            exp_q.push_back({i == er_at, d});
            i_mac.put(1'b1, d, i == er_at);
        end
        repeat (8) i_mac.put(1'b0, 4'h0, 1'b0);
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_in);
        cmp_bit(rx_dv | rx_er | crs, 1'b0);
        #1 rst_in = 1'b0;
        repeat (6) i_mac.put(1'b0, 4'h0, 1'b0);
        frame(4, -1);
        frame(16, 7);
        frame(1, 0);
        frame(5, 4);
        for (int f = 0; f < 3; f++) begin
            rng = xs(rng);
            frame(int'(rng[3:0]) + 1, -1);
        end
        repeat (4) i_mac.put(1'b0, 4'h0, 1'b0);
        cmp_bit(exp_q.size() == 0, 1'b1);
        cmp_bit(crs, 1'b0);
        finish_test();
    end
    // Watchdog well beyond the expected traffic time
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end
endmodule
